// ===== design/dsa_map.vh
// Purpose: constants for the data access and stack addressing block
// Assumes: 23-bit data word addresses, 24-bit address buses
// Notes:   memory-mapped offsets are data-space word addresses
`ifndef DSA_MAP_VH
`define DSA_MAP_VH
`define DSA_DADDR_W       23
`define DSA_BUS_W         24
`define DSA_IOADDR_W      16
`define DSA_PAGE_W        7
`define DSA_PTR_W         16
`define DSA_MMR_SP        23'h000018
`define DSA_MMR_SSP       23'h00004c
`define DSA_MMR_SPH       23'h00004e
`define DSA_SP_RST        16'h0000
`define DSA_SSP_RST       16'h0000
`define DSA_SPH_RST       7'h00
`define DSA_CFG_FAST      2'b00
`define DSA_CFG_SLOW      2'b01
`define DSA_CFG_LINKED    2'b10
`define DSA_CFG_RSVD      2'b11
`define DSA_VEC_CFG_HI    29
`define DSA_VEC_CFG_LO    28
`define DSA_SZ_BYTE       2'd0
`define DSA_SZ_WORD       2'd1
`define DSA_SZ_LONG       2'd2
`define DSA_OP_NONE       3'd0
`define DSA_OP_LOAD       3'd1
`define DSA_OP_STORE      3'd2
`define DSA_OP_IO_RD      3'd3
`define DSA_OP_IO_WR      3'd4
`define DSA_OP_PUSH       3'd5
`define DSA_OP_POP        3'd6
`define DSA_STK_DATA      2'd0
`define DSA_STK_SYS       2'd1
`define DSA_STK_BOTH      2'd2
`endif

// ===== design/dsa_byte_lane.v
// Purpose: byte selection, extension and merge for data-space byte access
// Assumes: purely combinational, 16-bit memory words
// Notes:   instantiated by dsa_core
`timescale 1ns/1ps
`default_nettype none
module dsa_byte_lane (
  input  wire [15:0] mem_word,
  input  wire        high_sel,
  input  wire        unsigned_q,
  input  wire [15:0] src_val,
  output wire [15:0] load_val,
  output wire [15:0] store_word
);
  wire [7:0] picked;

  // pick upper or lower half of the addressed word
  assign picked     = high_sel ? mem_word[15:8] : mem_word[7:0]; // [R2]
  // zero-extend with the unsigned qualifier, else sign-extend
  assign load_val   = {{8{~unsigned_q & picked[7]}}, picked}; // [R3]
  // low eight source bits go into the chosen byte; the other byte is kept
  assign store_word = high_sel ? {src_val[7:0], mem_word[7:0]}   // [R4] [R5]
                               : {mem_word[15:8], src_val[7:0]}; // [R4] [R5]
endmodule
`default_nettype wire

// ===== design/dsa_core.v
// Purpose: data/I-O address forming, operand sizing and stack pointer control
// Assumes: one request per cycle, memory read data returned before a store
// Notes:   byte stores are read-modify-write using the word on mem_rdata
//
// Notes on behaviour
// R1 - loads and stores handle byte, word and long word operands
// R2 - byte load picks bits 15-8 or 7-0 per high/low select
// R3 - loaded byte zero-extended when unsigned, sign-extended otherwise
// R4 - byte store writes the source's low eight bits into chosen byte
// R5 - byte store keeps the unselected byte of the word unchanged
// R6 - data addresses are 23-bit word addresses; bytes use their word
// R7 - long word is addressed by its upper half location
// R8 - lower half address is upper address with bit 0 inverted
// R9 - I/O space is separate, 16-bit word addresses, 64K locations
// R10 - I/O reads use data-read bus, writes use data-write bus
// R11 - I/O address zero-padded to 24 bits on the bus
// R12 - I/O address steps wrap at FFFFh and 0000h; unsupported use
// R13 - data stack address is page in 22-16 and pointer in 15-0
// R14 - push decrements then writes; pop reads then increments
// R15 - push and pop never change the stack page register
// R16 - system stack address is page plus system pointer, same pre/post
// R17 - linked configuration moves system pointer with data pointer
// R18 - dual configurations keep system pointer independent, context save only
// R19 - combined stack addresses have no memory-mapped location
// R20 - both 16-bit pointers reachable by instruction and memory map
// R21 - page register mapped; writes through combined addresses leave it
// R22 - stack configuration from reset vector bits 29:28
// R23 - data word address shifted left with zero to form bus address
`timescale 1ns/1ps
`default_nettype none
`include "dsa_map.vh"
module dsa_core (
  input  wire                    sys_clk,
  input  wire                    arst_n,
  input  wire                    cfg_load,
  input  wire [31:0]             reset_vector,
  input  wire                    req_valid,
  input  wire [2:0]              req_op,
  input  wire [1:0]              req_size,
  input  wire [1:0]              req_stack,
  input  wire                    req_high_byte,
  input  wire                    req_unsigned,
  input  wire                    req_second,
  input  wire [22:0]             req_addr,
  input  wire [31:0]             req_wdata,
  input  wire                    ptr_wr,
  input  wire [1:0]              ptr_sel,
  input  wire [15:0]             ptr_wdata,
  input  wire                    ext_wr,
  input  wire                    ext_sys,
  input  wire [22:0]             ext_wdata,
  input  wire [15:0]             mem_rdata,
  output reg  [23:0]             data_read_address_bus,
  output reg  [23:0]             data_write_address_bus,
  output reg                     rd_en,
  output reg                     wr_en,
  output reg  [15:0]             wr_data,
  output reg                     io_space,
  output reg  [31:0]             load_data,
  output reg                     load_valid,
  output reg  [22:0]             data_stack_address_ext,
  output reg  [22:0]             system_stack_address_ext,
  output reg  [15:0]             mmr_rdata,
  output reg  [1:0]              stack_cfg,
  output reg                     cfg_illegal
);
  reg  [15:0] data_stack_pointer_r;
  reg  [15:0] system_stack_pointer_r;
  reg  [6:0]  stack_page_high_r;
  reg  [1:0]  stack_cfg_r;
  reg  [15:0] sp_nxt;
  reg  [15:0] ssp_nxt;
  reg  [6:0]  sph_nxt;
  reg  [22:0] waddr;
  reg  [22:0] stk_addr;
  reg  [15:0] io_addr;
  reg  [15:0] half;
  reg         mv_data;
  reg         mv_sys;
  wire [15:0] byte_load;
  wire [15:0] byte_store;
  wire        linked;
  wire [1:0]  cfg_nxt;

  assign linked = (stack_cfg_r == `DSA_CFG_LINKED);
  // visible configuration follows the vector one edge after cfg_load, not two
  assign cfg_nxt = cfg_load ? reset_vector[`DSA_VEC_CFG_HI:`DSA_VEC_CFG_LO] : stack_cfg_r; // [R22]

  dsa_byte_lane u_lane (
    .mem_word   (mem_rdata),
    .high_sel   (req_high_byte),
    .unsigned_q (req_unsigned),
    .src_val    (req_wdata[15:0]),
    .load_val   (byte_load),
    .store_word (byte_store)
  );

  // stack configuration is sampled from the reset vector word after reset
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      stack_cfg_r <= `DSA_CFG_FAST;
    end else if (cfg_load) begin
      stack_cfg_r <= reset_vector[`DSA_VEC_CFG_HI:`DSA_VEC_CFG_LO]; // [R22]
    end
  end

  // pointer next values; page register only moves by its mapped write
  always @* begin
    sp_nxt  = data_stack_pointer_r;
    ssp_nxt = system_stack_pointer_r;
    sph_nxt = stack_page_high_r; // [R15]
    mv_data = 1'b0;
    mv_sys  = 1'b0;
    if (req_valid && (req_op == `DSA_OP_PUSH || req_op == `DSA_OP_POP)) begin
      mv_data = (req_stack != `DSA_STK_SYS);
      // context save touches the system stack in any configuration
      mv_sys  = (req_stack != `DSA_STK_DATA) || (linked && mv_data); // [R17] [R18]
      if (req_op == `DSA_OP_PUSH) begin
        if (mv_data) sp_nxt = data_stack_pointer_r - 16'h0001; // [R14]
        if (mv_sys)  ssp_nxt = system_stack_pointer_r - 16'h0001; // [R16]
      end else begin
        if (mv_data) sp_nxt = data_stack_pointer_r + 16'h0001; // [R14]
        if (mv_sys)  ssp_nxt = system_stack_pointer_r + 16'h0001; // [R16]
      end
    end
    // dedicated instruction / mapped writes; mapped pointer write does not relink
    if (ptr_wr) begin
      case (ptr_sel)
        2'd0: sp_nxt = ptr_wdata; // [R20]
        2'd1: ssp_nxt = ptr_wdata; // [R20]
        2'd2: sph_nxt = ptr_wdata[6:0]; // [R21]
        default: sph_nxt = stack_page_high_r;
      endcase
    end
    // combined-address writes load only the pointer part
    if (ext_wr) begin
      if (ext_sys) ssp_nxt = ext_wdata[15:0]; // [R21]
      else         sp_nxt  = ext_wdata[15:0]; // [R21]
    end
  end

  // address forming for the current request
  always @* begin
    waddr    = req_addr; // [R6] [R7]
    if (req_op != `DSA_OP_PUSH && req_op != `DSA_OP_POP && req_size == `DSA_SZ_LONG && req_second) begin
      waddr = {req_addr[22:1], ~req_addr[0]}; // [R8]
    end
    io_addr  = req_addr[15:0]; // [R9] [R12] 16-bit space, wraps naturally
    stk_addr = (req_stack == `DSA_STK_SYS) ? {stack_page_high_r, ssp_nxt}  // [R16]
                                           : {stack_page_high_r, sp_nxt}; // [R13]
    if (req_op == `DSA_OP_POP) begin
      stk_addr = (req_stack == `DSA_STK_SYS) ? {stack_page_high_r, system_stack_pointer_r}
                                             : {stack_page_high_r, data_stack_pointer_r}; // [R14]
    end
    half = req_second ? req_wdata[15:0] : req_wdata[31:16]; // [R7] upper half first
  end

  // registered bus outputs
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      data_read_address_bus  <= 24'h000000;
      data_write_address_bus <= 24'h000000;
      rd_en                  <= 1'b0;
      wr_en                  <= 1'b0;
      wr_data                <= 16'h0000;
      io_space               <= 1'b0;
      load_data              <= 32'h00000000;
      load_valid             <= 1'b0;
    end else begin
      rd_en      <= 1'b0;
      wr_en      <= 1'b0;
      load_valid <= 1'b0;
      io_space   <= 1'b0;
      if (req_valid) begin
        case (req_op)
          `DSA_OP_LOAD: begin
            data_read_address_bus <= {waddr, 1'b0}; // [R23]
            rd_en      <= 1'b1;
            load_valid <= 1'b1;
            case (req_size) // [R1]
              `DSA_SZ_BYTE: load_data <= {{16{byte_load[15]}}, byte_load}; // [R2] [R3]
              `DSA_SZ_WORD: load_data <= {16'h0000, mem_rdata};
              default: begin
                if (req_second) load_data <= {load_data[31:16], mem_rdata}; // [R8]
                else            load_data <= {mem_rdata, 16'h0000}; // [R7]
              end
            endcase
          end
          `DSA_OP_STORE: begin
            data_write_address_bus <= {waddr, 1'b0}; // [R23]
            wr_en   <= 1'b1;
            case (req_size) // [R1]
              `DSA_SZ_BYTE: wr_data <= byte_store; // [R4] [R5]
              `DSA_SZ_WORD: wr_data <= req_wdata[15:0];
              default:      wr_data <= half; // [R7] [R8]
            endcase
          end
          `DSA_OP_IO_RD: begin
            data_read_address_bus <= {8'h00, io_addr}; // [R10] [R11]
            rd_en      <= 1'b1;
            io_space   <= 1'b1; // [R9]
            load_valid <= 1'b1;
            load_data  <= {16'h0000, mem_rdata};
          end
          `DSA_OP_IO_WR: begin
            data_write_address_bus <= {8'h00, io_addr}; // [R10] [R11]
            wr_en    <= 1'b1;
            io_space <= 1'b1; // [R9]
            wr_data  <= req_wdata[15:0];
          end
          `DSA_OP_PUSH: begin
            data_write_address_bus <= {stk_addr, 1'b0}; // [R14] [R23]
            wr_en   <= 1'b1;
            wr_data <= req_wdata[15:0];
          end
          `DSA_OP_POP: begin
            data_read_address_bus <= {stk_addr, 1'b0}; // [R14] [R23]
            rd_en      <= 1'b1;
            load_valid <= 1'b1;
            load_data  <= {16'h0000, mem_rdata};
          end
          default: rd_en <= 1'b0;
        endcase
      end
    end
  end

  // pointer registers and visible state
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      data_stack_pointer_r     <= `DSA_SP_RST;
      system_stack_pointer_r   <= `DSA_SSP_RST;
      stack_page_high_r        <= `DSA_SPH_RST;
      data_stack_address_ext   <= 23'h000000;
      system_stack_address_ext <= 23'h000000;
      stack_cfg                <= `DSA_CFG_FAST;
      cfg_illegal              <= 1'b0;
    end else begin
      data_stack_pointer_r     <= sp_nxt;
      system_stack_pointer_r   <= ssp_nxt;
      stack_page_high_r        <= sph_nxt;
      // combined addresses exist only as dedicated outputs, not mapped
      data_stack_address_ext   <= {sph_nxt, sp_nxt};  // [R13] [R19]
      system_stack_address_ext <= {sph_nxt, ssp_nxt}; // [R16] [R19]
      stack_cfg                <= cfg_nxt; // [R22]
      cfg_illegal              <= (cfg_nxt == `DSA_CFG_RSVD); // [R22]
    end
  end

  // memory-mapped read of pointers and page; reads see the updated value
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      mmr_rdata <= 16'h0000;
    end else begin
      case (req_addr)
        `DSA_MMR_SP:  mmr_rdata <= sp_nxt;  // [R20]
        `DSA_MMR_SSP: mmr_rdata <= ssp_nxt; // [R20]
        `DSA_MMR_SPH: mmr_rdata <= {9'h000, sph_nxt}; // [R21]
        default:      mmr_rdata <= 16'h0000;
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== tb/dsa_mem_model.sv
// Purpose: word memory and peripheral register space facing dsa_core
// Assumes: read word returned in the request cycle, writes land on wr_en
// Notes:   only 256 words of each space exist, so addresses alias
`timescale 1ns/1ps
`default_nettype none
module dsa_mem_model (
  input  wire logic        sys_clk,
  input  wire logic        req_valid,
  input  wire logic [2:0]  req_op,
  input  wire logic [1:0]  req_stack,
  input  wire logic        req_second,
  input  wire logic [22:0] req_addr,
  input  wire logic [22:0] data_stack_address_ext,
  input  wire logic [22:0] system_stack_address_ext,
  input  wire logic        wr_en,
  input  wire logic        io_space,
  input  wire logic [23:0] data_write_address_bus,
  input  wire logic [15:0] wr_data,
  output logic      [15:0] mem_rdata
);
  logic [15:0] ram [0:255];
  logic [15:0] io  [0:255];
  logic [15:0] junk_r = 16'h5a5a;
  logic [7:0]  ra;
  // pops read at the stack top; a long's second half sits at the paired word
  always_comb begin
    ra = req_op == 3'h6 ? (req_stack == 2'h1 ? system_stack_address_ext[7:0] : data_stack_address_ext[7:0])
                        : req_addr[7:0] ^ {7'h0, req_second};
    mem_rdata = !req_valid ? junk_r : (req_op == 3'h3 ? io[ra] : ram[ra]);
  end
  // idle read lines toggle so a stale word is never taken for data
  always @(posedge sys_clk) begin
    junk_r <= ~junk_r;
    if (wr_en && io_space)
      io[data_write_address_bus[7:0]] <= wr_data;
    else if (wr_en)
      ram[data_write_address_bus[8:1]] <= wr_data;
  end
endmodule
`default_nettype wire

// ===== tb/dsa_core_props.sv
// Purpose: port-level properties of dsa_core
// Assumes: one clock domain, answers one cycle after the request edge
// Notes:   mapped pointer writes in the same cycle are excluded
`timescale 1ns/1ps
`default_nettype none
module dsa_core_props (
  input wire logic        sys_clk,
  input wire logic        arst_n,
  input wire logic        cfg_load,
  input wire logic [31:0] reset_vector,
  input wire logic        req_valid,
  input wire logic [2:0]  req_op,
  input wire logic [1:0]  req_size,
  input wire logic [1:0]  req_stack,
  input wire logic        req_second,
  input wire logic [22:0] req_addr,
  input wire logic        ptr_wr,
  input wire logic        ext_wr,
  input wire logic [23:0] data_read_address_bus,
  input wire logic [23:0] data_write_address_bus,
  input wire logic        rd_en,
  input wire logic        wr_en,
  input wire logic        io_space,
  input wire logic [22:0] data_stack_address_ext,
  input wire logic [22:0] system_stack_address_ext,
  input wire logic [1:0]  stack_cfg
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // slices kept as nets so sampled-value calls see plain signals
  wire logic [15:0] dsp   = data_stack_address_ext[15:0];
  wire logic [15:0] system_stack_pointer   = system_stack_address_ext[15:0];
  wire logic [6:0]  pg    = data_stack_address_ext[22:16];
  wire logic [15:0] io_a  = req_addr[15:0];
  wire logic [1:0]  vcfg  = reset_vector[29:28];
  wire logic        dpush = req_valid && req_op == 3'h5 && req_stack == 2'h0 && !ptr_wr && !ext_wr;
  wire logic        dpop  = req_valid && req_op == 3'h6 && req_stack == 2'h0 && !ptr_wr && !ext_wr;
  chk_push_predec: assert property (dpush |=> wr_en && data_write_address_bus == {data_stack_address_ext, 1'b0}
    && {pg, dsp} == {$past(pg), $past(dsp) - 16'h1}) else $error("push address or pointer wrong");
  chk_pop_postinc: assert property (dpop |=> rd_en && data_read_address_bus == {$past(data_stack_address_ext), 1'b0}
    && {pg, dsp} == {$past(pg), $past(dsp) + 16'h1}) else $error("pop address or pointer wrong");
  chk_linked_move: assert property (dpush && stack_cfg == 2'h2 |=> system_stack_pointer == $past(system_stack_pointer) - 16'h1)
    else $error("linked system pointer did not follow");
  chk_dual_hold: assert property ((dpush || dpop) && stack_cfg != 2'h2 |=> $stable(system_stack_pointer))
    else $error("dual system pointer moved");
  chk_io_read_bus: assert property (req_valid && req_op == 3'h3 |=> rd_en && io_space
    && data_read_address_bus == {8'h00, $past(io_a)}) else $error("io read address wrong");
  chk_io_write_bus: assert property (req_valid && req_op == 3'h4 |=> wr_en && io_space
    && data_write_address_bus == {8'h00, $past(io_a)}) else $error("io write address wrong");
  chk_long_lower: assert property (req_valid && req_op == 3'h1 && req_size == 2'h2 && req_second
    |=> data_read_address_bus == {$past(req_addr) ^ 23'h1, 1'b0}) else $error("long lower half address wrong");
  chk_cfg_take: assert property (cfg_load |=> stack_cfg == $past(vcfg))
    else $error("stack configuration not taken");
endmodule
bind dsa_core dsa_core_props u_props (.sys_clk(sys_clk), .arst_n(arst_n), .cfg_load(cfg_load),
  .reset_vector(reset_vector), .req_valid(req_valid), .req_op(req_op), .req_size(req_size),
  .req_stack(req_stack), .req_second(req_second), .req_addr(req_addr), .ptr_wr(ptr_wr), .ext_wr(ext_wr),
  .data_read_address_bus(data_read_address_bus), .data_write_address_bus(data_write_address_bus),
  .rd_en(rd_en), .wr_en(wr_en), .io_space(io_space), .data_stack_address_ext(data_stack_address_ext),
  .system_stack_address_ext(system_stack_address_ext), .stack_cfg(stack_cfg));
`default_nettype wire

// ===== tb/tb.sv
// Purpose: self-checking bench for dsa_core with a memory model
// Assumes: inputs change on the falling edge, answers one cycle later
// Notes:   random data from a fixed lfsr seed
`timescale 1ns/1ps
`default_nettype none
`include "dsa_map.vh"
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin miscompares++; $display("MISMATCH %s exp %h got %h", n, e, s); end end
module tb;
  logic        sys_clk = 0, arst_n = 0, cfg_load = 0, req_valid = 0, req_high_byte = 0, req_unsigned = 0;
  logic        req_second = 0, ptr_wr = 0, ext_wr = 0, ext_sys = 0, rd_en, wr_en, io_space, load_valid, cfg_illegal, hi;
  logic [31:0] reset_vector = 0, req_wdata = 0, rnd_r = 32'd74805, load_data;
  logic [2:0]  req_op = 0;
  logic [1:0]  req_size = 0, req_stack = 0, ptr_sel = 0, stack_cfg;
  logic [22:0] req_addr = 0, ext_wdata = 0, data_stack_address_ext, system_stack_address_ext, a;
  logic [23:0] data_read_address_bus, data_write_address_bus;
  logic [15:0] ptr_wdata = 0, mem_rdata, wr_data, mmr_rdata, w, sp;
  logic [6:0]  pg;
  int          miscompares = 0, checks_done = 0;
  dsa_core dut (.sys_clk(sys_clk), .arst_n(arst_n), .cfg_load(cfg_load), .reset_vector(reset_vector),
    .req_valid(req_valid), .req_op(req_op), .req_size(req_size), .req_stack(req_stack), .req_high_byte(req_high_byte),
    .req_unsigned(req_unsigned), .req_second(req_second), .req_addr(req_addr), .req_wdata(req_wdata), .ptr_wr(ptr_wr),
    .ptr_sel(ptr_sel), .ptr_wdata(ptr_wdata), .ext_wr(ext_wr), .ext_sys(ext_sys), .ext_wdata(ext_wdata),
    .mem_rdata(mem_rdata), .data_read_address_bus(data_read_address_bus), .data_write_address_bus(data_write_address_bus),
    .rd_en(rd_en), .wr_en(wr_en), .wr_data(wr_data), .io_space(io_space), .load_data(load_data), .load_valid(load_valid),
    .data_stack_address_ext(data_stack_address_ext), .system_stack_address_ext(system_stack_address_ext),
    .mmr_rdata(mmr_rdata), .stack_cfg(stack_cfg), .cfg_illegal(cfg_illegal));
  dsa_mem_model u_mem (.sys_clk(sys_clk), .req_valid(req_valid), .req_op(req_op), .req_stack(req_stack),
    .req_second(req_second), .req_addr(req_addr), .data_stack_address_ext(data_stack_address_ext),
    .system_stack_address_ext(system_stack_address_ext), .wr_en(wr_en), .io_space(io_space),
    .data_write_address_bus(data_write_address_bus), .wr_data(wr_data), .mem_rdata(mem_rdata));
  // 50 ns clock
  always #25 sys_clk = ~sys_clk;
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // expected byte load: pick a half, then widen by sign or zero
  function automatic logic [15:0] xb(input logic [15:0] v, input logic h, input logic u);
    logic [7:0] b;
    b = h ? v[15:8] : v[7:0];
    return {u ? 8'h00 : {8{b[7]}}, b};
  endfunction
  task automatic issue(input logic [2:0] op, input logic [1:0] sz, input logic [1:0] stk, input logic h,
                       input logic u, input logic sec, input logic [22:0] ad, input logic [31:0] wd);
    @(negedge sys_clk);
    {req_valid, req_op, req_size, req_stack, req_high_byte, req_unsigned, req_second} = {1'b1, op, sz, stk, h, u, sec};
    req_addr = ad;
    req_wdata = wd;
    @(negedge sys_clk);
    req_valid = 0;
  endtask
  task automatic pset(input logic [1:0] s, input logic [15:0] d);
    @(negedge sys_clk);
    {ptr_wr, ptr_sel, ptr_wdata} = {1'b1, s, d};
    @(negedge sys_clk);
    ptr_wr = 0;
  endtask
  task automatic setcfg(input logic [1:0] c);
    @(negedge sys_clk);
    rnd_r = nxt(rnd_r);
    cfg_load = 1;
    reset_vector = {rnd_r[31:30], c, rnd_r[27:0]};
    @(negedge sys_clk);
    cfg_load = 0;
  endtask
  task automatic end_sim;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // watchdog: the whole sequence needs well under 1000 cycles
  initial begin
    #100000;
    miscompares++;
    end_sim();
  end
  // main sequence
  initial begin
    repeat (20) @(posedge sys_clk);
    @(negedge sys_clk);
    arst_n = 1;
    `CHK("xsp_rst", 23'h0, data_stack_address_ext)
    for (int c = 0; c < 4; c++) begin
      setcfg(c[1:0]);
      `CHK("illegal", c == 3, cfg_illegal)
    end
    for (int i = 0; i < 6; i++) begin
      rnd_r = nxt(rnd_r);
      {a, w, hi} = {rnd_r[22:0], rnd_r[31:16], rnd_r[8]};
      issue(`DSA_OP_STORE, `DSA_SZ_WORD, 0, 0, 0, 0, a, {16'h0, w});
      `CHK("word_st", w, wr_data)
      issue(`DSA_OP_LOAD, `DSA_SZ_BYTE, 0, hi, rnd_r[9], 0, a, 0);
      `CHK("byte_ld", xb(w, hi, rnd_r[9]), load_data[15:0])
      `CHK("ld_valid", 1'b1, load_valid)
      issue(`DSA_OP_STORE, `DSA_SZ_BYTE, 0, hi, 0, 0, a, rnd_r);
      `CHK("byte_st", hi ? {rnd_r[7:0], w[7:0]} : {w[15:8], rnd_r[7:0]}, wr_data)
      issue(`DSA_OP_STORE, `DSA_SZ_LONG, 0, 0, 0, 0, a, rnd_r);
      issue(`DSA_OP_STORE, `DSA_SZ_LONG, 0, 0, 0, 1, a, rnd_r);
      issue(`DSA_OP_LOAD, `DSA_SZ_LONG, 0, 0, 0, 0, a, 0);
      issue(`DSA_OP_LOAD, `DSA_SZ_LONG, 0, 0, 0, 1, a, 0);
      `CHK("long_ld", rnd_r, load_data)
      a = {7'h0, i == 0 ? 16'hffff : rnd_r[15:0]};
      issue(`DSA_OP_IO_WR, `DSA_SZ_WORD, 0, 0, 0, 0, a, ~rnd_r);
      issue(`DSA_OP_IO_RD, `DSA_SZ_WORD, 0, 0, 0, 0, a, 0);
      `CHK("io_rd", ~rnd_r[15:0], load_data[15:0])
    end
    for (int k = 0; k < 3; k++) begin
      rnd_r = nxt(rnd_r);
      pg = rnd_r[6:0];
      sp = k ? 16'h0000 : rnd_r[31:16];
      setcfg(k == 0 ? `DSA_CFG_LINKED : k == 1 ? `DSA_CFG_FAST : `DSA_CFG_SLOW);
      pset(2, {9'h0, pg});
      pset(0, sp);
      pset(1, 16'h8000);
      issue(`DSA_OP_PUSH, `DSA_SZ_WORD, `DSA_STK_DATA, 0, 0, 0, 0, rnd_r);
      `CHK("xsp_push", {pg, sp - 16'h1}, data_stack_address_ext)
      `CHK("system_stack_address_ext_push", {pg, k ? 16'h8000 : 16'h7fff}, system_stack_address_ext)
      issue(`DSA_OP_POP, `DSA_SZ_WORD, `DSA_STK_DATA, 0, 0, 0, 0, 0);
      `CHK("pop", rnd_r[15:0], load_data[15:0])
      `CHK("xsp_pop", {pg, sp}, data_stack_address_ext)
      issue(`DSA_OP_PUSH, `DSA_SZ_WORD, `DSA_STK_BOTH, 0, 0, 0, 0, ~rnd_r);
      `CHK("both_ssp", {pg, 16'h7fff}, system_stack_address_ext)
      `CHK("both_sp", {pg, sp - 16'h1}, data_stack_address_ext)
      @(negedge sys_clk);
      {ext_wr, ext_sys, ext_wdata} = {1'b1, k[0], ~pg, 16'h1234};
      @(negedge sys_clk);
      ext_wr = 0;
      `CHK("ext_wr", {pg, 16'h1234}, k[0] ? system_stack_address_ext : data_stack_address_ext)
      issue(`DSA_OP_LOAD, `DSA_SZ_WORD, 0, 0, 0, 0, k[0] ? `DSA_MMR_SSP : `DSA_MMR_SP, 0);
      `CHK("mmr", 16'h1234, mmr_rdata)
    end
    end_sim();
  end
endmodule
`default_nettype wire
